// File: hw/mpd_core.sv
// module: executor for arithmetic, copy and parameter override program blocks
`timescale 1ns/1ps
`default_nettype none
module mpd_core #(
  parameter int NREG = 32
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  output logic                      o_irq,
  input  wire logic                 i_cmd_valid,
  input  wire mpd_pkg::kind_e       i_cmd_kind,
  input  wire mpd_pkg::op_e         i_op,
  input  wire logic                 i_dst_reg,
  input  wire logic [10:0]          i_dst_addr,
  input  wire mpd_pkg::src_e        i_s2_sel,
  input  wire logic [10:0]          i_s2_addr,
  input  wire logic signed [47:0]   i_s2_imm,
  input  wire mpd_pkg::src_e        i_s3_sel,
  input  wire logic [10:0]          i_s3_addr,
  input  wire logic signed [47:0]   i_s3_imm,
  input  wire logic [2:0]           i_ovr_type,
  input  wire logic                 i_ovr_axis,
  output logic                      o_cmd_ready,
  output logic                      o_cmd_done,
  output logic                      o_cmd_err,
  input  wire logic                 i_motion_start,
  input  wire logic                 i_motion_interp,
  input  wire logic                 i_main_start,
  input  wire logic signed [31:0]   i_pos_x,
  input  wire logic signed [31:0]   i_pos_y,
  output logic                      o_pd_rd_en,
  output logic      [10:0]          o_pd_rd_addr,
  input  wire logic signed [47:0]   i_pd_rd_data,
  output logic                      o_pd_wr_en,
  output logic      [10:0]          o_pd_wr_addr,
  output logic signed [47:0]        o_pd_wr_data,
  input  wire logic [13:0]          i_sys_time [mpd_pkg::NOVR],
  output logic      [13:0]          o_eff_time [mpd_pkg::NOVR]
);
  localparam int RA = $clog2(NREG);

  typedef enum logic [2:0] {S_IDLE, S_RD2, S_DAT2, S_RD3, S_DAT3, S_EXEC} state_e;

  // ==========================================================
  // helpers
  function automatic logic signed [95:0] fmag(input logic signed [95:0] v);
    return (v < 0) ? -v : v;
  endfunction

  // quotient rounded half away from zero
  function automatic logic signed [95:0] rdiv(input logic signed [95:0] n,
                                              input logic signed [95:0] d);
    logic signed [95:0] nm;
    logic signed [95:0] dm;
    logic signed [95:0] q;
    nm = fmag(n);
    dm = fmag(d);
    q  = (dm == 0) ? 96'sh0 : (2 * nm + dm) / (2 * dm);
    return ((n < 0) != (d < 0)) ? -q : q;
  endfunction

  function automatic logic signed [95:0] rnd_fx(input logic signed [95:0] v);
    return rdiv(v, mpd_pkg::FRAC_W) * mpd_pkg::FRAC_W;
  endfunction

  function automatic logic imm_bad(input mpd_pkg::src_e s, input logic signed [47:0] v);
    return (s == mpd_pkg::SRC_IMM) && (fmag(96'(v)) > mpd_pkg::POS_MAX_W);
  endfunction

  // ==========================================================
  // register bus
  logic [2:0]  st_reg, st_next, en_reg, en_next, clr;
  logic        pass_reg, pass_next;
  logic [31:0] scl_reg [mpd_pkg::NAX];
  logic [31:0] scl_next [mpd_pkg::NAX];
  logic [31:0] rdata_next;
  logic [2:0]  ev;
  logic [7:0]  act_vld;

  always_comb begin
    en_next     = en_reg;
    pass_next   = pass_reg;
    scl_next    = scl_reg;
    clr         = 3'h0;
    rdata_next  = 32'h0;
    if (i_wr) begin
      case (i_addr)
        mpd_pkg::OFS_INT_EN:  en_next = i_wdata[2:0];
        mpd_pkg::OFS_INT_CLR: clr = i_wdata[2:0];
        mpd_pkg::OFS_CTRL:    pass_next = i_wdata[mpd_pkg::CTRL_PASS];
        mpd_pkg::OFS_SCALE_X: scl_next[0] = i_wdata;
        mpd_pkg::OFS_SCALE_Y: scl_next[1] = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        mpd_pkg::OFS_STATUS:  rdata_next = {29'h0, st_reg};
        mpd_pkg::OFS_INT_EN:  rdata_next = {29'h0, en_reg};
        mpd_pkg::OFS_CTRL:    rdata_next = {31'h0, pass_reg};
        mpd_pkg::OFS_SCALE_X: rdata_next = scl_reg[0];
        mpd_pkg::OFS_SCALE_Y: rdata_next = scl_reg[1];
        mpd_pkg::OFS_OVR_ACT: rdata_next = {24'h0, act_vld};
        default:              rdata_next = 32'h0;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_next = (st_reg & ~clr) | ev;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_reg   <= mpd_pkg::ST_RST;
      en_reg   <= mpd_pkg::ST_RST;
      pass_reg <= mpd_pkg::CTRL_RST;
      scl_reg  <= '{default: mpd_pkg::SCALE_RST};
      o_rdata  <= 32'h0;
    end else begin
      st_reg   <= st_next;
      en_reg   <= en_next;
      pass_reg <= pass_next;
      scl_reg  <= scl_next;
      o_rdata  <= rdata_next;
    end
  end

  assign o_irq = |(st_reg & en_reg);

  // ==========================================================
  // index registers
  logic [10:0] idx_reg [NREG];
  logic [10:0] idx_next [NREG];
  logic        idx_we;
  logic [10:0] idx_wval;
  logic [RA-1:0] dst_a;

  always_comb begin
    idx_next = idx_reg;
    if (idx_we) begin
      idx_next[dst_a] = idx_wval;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idx_reg <= '{default: 11'h000};
    end else begin
      idx_reg <= idx_next;
    end
  end

  // ==========================================================
  // source operands and command sequencer
  state_e              state_reg, state_next;
  mpd_pkg::kind_e      kind_reg, kind_next;
  mpd_pkg::op_e        op_reg, op_next;
  logic                dreg_reg, dreg_next, bad_reg, bad_next, s3pd_reg, s3pd_next;
  logic [10:0]         dst_reg_a, dst_next, s3a_reg, s3a_next;
  logic [2:0]          oidx_reg, oidx_next;
  logic                otype_ok_reg, otype_ok_next;
  logic signed [47:0]  a_reg, a_next, b_reg, b_next;
  logic                rd_en_next, wr_en_next, done_next, err_next, ovr_we;
  logic [10:0]         rd_addr_next, wr_addr_next;
  logic signed [47:0]  wr_data_next;
  logic signed [47:0]  ax_fx [mpd_pkg::NAX];
  logic signed [95:0]  res;
  logic                rng_bad, div0;
  logic [13:0]         ovr_val;

  // axis present position scaled to user units
  // operands widened to 48 bits first, so the product keeps only its low 48 bits
  assign ax_fx[0] = 48'(i_pos_x) * 48'($signed(scl_reg[0]));
  assign ax_fx[1] = 48'(i_pos_y) * 48'($signed(scl_reg[1]));
  assign dst_a    = dst_reg_a[RA-1:0];

  function automatic logic signed [47:0] src_fx(input mpd_pkg::src_e s,
                                                input logic signed [47:0] imm,
                                                input logic [10:0] rv,
                                                input logic signed [47:0] ax);
    case (s)
      mpd_pkg::SRC_REG:  return $signed({37'h0, rv}) * mpd_pkg::FRAC;
      mpd_pkg::SRC_IMM:  return imm;
      mpd_pkg::SRC_AXIS: return ax;
      default:           return 48'sh0;
    endcase
  endfunction

  always_comb begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    op_next       = op_reg;
    dreg_next     = dreg_reg;
    bad_next      = bad_reg;
    s3pd_next     = s3pd_reg;
    dst_next      = dst_reg_a;
    s3a_next      = s3a_reg;
    oidx_next     = oidx_reg;
    otype_ok_next = otype_ok_reg;
    a_next        = a_reg;
    b_next        = b_reg;
    rd_en_next    = 1'b0;
    rd_addr_next  = o_pd_rd_addr;
    wr_en_next    = 1'b0;
    wr_addr_next  = o_pd_wr_addr;
    wr_data_next  = o_pd_wr_data;
    done_next     = 1'b0;
    err_next      = 1'b0;
    idx_we        = 1'b0;
    ovr_we        = 1'b0;
    ev            = 3'h0;
    case (state_reg)
      S_IDLE: if (i_cmd_valid) begin
        kind_next     = i_cmd_kind;
        op_next       = i_op;
        dreg_next     = i_dst_reg;
        dst_next      = i_dst_addr;
        s3a_next      = i_s3_addr;
        oidx_next     = {i_ovr_axis, 2'(i_ovr_type - 3'h1)};
        otype_ok_next = (i_ovr_type >= 3'h1) && (i_ovr_type <= 3'h4);
        s3pd_next     = (i_cmd_kind == mpd_pkg::CMD_ARITH) && (i_s3_sel == mpd_pkg::SRC_PD);
        a_next = src_fx(i_s2_sel, i_s2_imm, idx_reg[i_s2_addr[RA-1:0]],
                        ax_fx[i_s2_addr[0]]);
        b_next = src_fx(i_s3_sel, i_s3_imm, idx_reg[i_s3_addr[RA-1:0]],
                        ax_fx[i_s3_addr[0]]);
        bad_next = imm_bad(i_s2_sel, i_s2_imm)
                   || ((i_cmd_kind == mpd_pkg::CMD_ARITH) && imm_bad(i_s3_sel, i_s3_imm));
        if (i_s2_sel == mpd_pkg::SRC_PD) begin
          state_next   = S_RD2;
          rd_en_next   = 1'b1;
          rd_addr_next = i_s2_addr;
        end else if (s3pd_next) begin
          state_next   = S_RD3;
          rd_en_next   = 1'b1;
          rd_addr_next = i_s3_addr;
        end else begin
          state_next = S_EXEC;
        end
      end
      S_RD2: state_next = S_DAT2;
      S_DAT2: begin
        a_next = i_pd_rd_data;
        if (s3pd_reg) begin
          state_next   = S_RD3;
          rd_en_next   = 1'b1;
          rd_addr_next = s3a_reg;
        end else begin
          state_next = S_EXEC;
        end
      end
      S_RD3: state_next = S_DAT3;
      S_DAT3: begin
        b_next     = i_pd_rd_data;
        state_next = S_EXEC;
      end
      S_EXEC: begin
        state_next = S_IDLE;
        done_next  = 1'b1;
        ev[mpd_pkg::ST_DONE] = 1'b1;
        if (bad_reg || rng_bad) begin
          err_next = 1'b1;
          ev[mpd_pkg::ST_RANGE] = 1'b1;
        end else if (div0) begin
          err_next = 1'b1;
          ev[mpd_pkg::ST_DIV0] = 1'b1;
        end else if (kind_reg == mpd_pkg::CMD_OVR) begin
          ovr_we = 1'b1;
        end else if (dreg_reg) begin
          idx_we = 1'b1;
        end else begin
          wr_en_next   = 1'b1;
          wr_addr_next = dst_reg_a;
          wr_data_next = res[47:0];
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg    <= S_IDLE;
      kind_reg     <= mpd_pkg::CMD_ARITH;
      op_reg       <= mpd_pkg::OP_ADD;
      dreg_reg     <= 1'b0;
      bad_reg      <= 1'b0;
      s3pd_reg     <= 1'b0;
      dst_reg_a    <= 11'h000;
      s3a_reg      <= 11'h000;
      oidx_reg     <= 3'h0;
      otype_ok_reg <= 1'b0;
      a_reg        <= 48'sh0;
      b_reg        <= 48'sh0;
      o_pd_rd_en   <= 1'b0;
      o_pd_rd_addr <= 11'h000;
      o_pd_wr_en   <= 1'b0;
      o_pd_wr_addr <= 11'h000;
      o_pd_wr_data <= 48'sh0;
      o_cmd_done   <= 1'b0;
      o_cmd_err    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      kind_reg     <= kind_next;
      op_reg       <= op_next;
      dreg_reg     <= dreg_next;
      bad_reg      <= bad_next;
      s3pd_reg     <= s3pd_next;
      dst_reg_a    <= dst_next;
      s3a_reg      <= s3a_next;
      oidx_reg     <= oidx_next;
      otype_ok_reg <= otype_ok_next;
      a_reg        <= a_next;
      b_reg        <= b_next;
      o_pd_rd_en   <= rd_en_next;
      o_pd_rd_addr <= rd_addr_next;
      o_pd_wr_en   <= wr_en_next;
      o_pd_wr_addr <= wr_addr_next;
      o_pd_wr_data <= wr_data_next;
      o_cmd_done   <= done_next;
      o_cmd_err    <= err_next;
    end
  end

  assign o_cmd_ready = (state_reg == S_IDLE);

  // ==========================================================
  // datapath, evaluated in the execute state
  logic signed [95:0] ea, eb;

  always_comb begin
    ea = dreg_reg ? rnd_fx(96'(a_reg)) : 96'(a_reg);
    eb = dreg_reg ? rnd_fx(96'(b_reg)) : 96'(b_reg);
    case (op_reg)
      mpd_pkg::OP_ADD: res = ea + eb;
      mpd_pkg::OP_SUB: res = ea - eb;
      // products and quotients are brought back to four digits
      mpd_pkg::OP_MUL: res = rdiv(ea * eb, mpd_pkg::FRAC_W);
      default:         res = rdiv(ea * mpd_pkg::FRAC_W, eb);
    endcase
    if (kind_reg != mpd_pkg::CMD_ARITH) begin
      res = ea;
    end
    if (kind_reg == mpd_pkg::CMD_OVR) begin
      res = rnd_fx(96'(a_reg));
    end else if (dreg_reg) begin
      res = rnd_fx(res);
    end
    div0 = (kind_reg == mpd_pkg::CMD_ARITH) && (op_reg == mpd_pkg::OP_DIV) && (eb == 0);
    if (kind_reg == mpd_pkg::CMD_OVR) begin
      rng_bad = !otype_ok_reg || (res < 0) || (res > mpd_pkg::OVR_LIM_W);
    end else if (dreg_reg) begin
      rng_bad = (res < 0) || (res > mpd_pkg::REG_LIM_W);
    end else begin
      rng_bad = fmag(res) > mpd_pkg::POS_MAX_W;
    end
    idx_wval = 11'(res / mpd_pkg::FRAC_W);
    ovr_val  = 14'(res / mpd_pkg::FRAC_W);
  end

  // ==========================================================
  // parameter overrides, one entry per axis and type
  logic [13:0] pend_val [mpd_pkg::NOVR];
  logic [13:0] act_val  [mpd_pkg::NOVR];
  logic [7:0]  pend_vld;

  genvar g;
  generate
    for (g = 0; g < mpd_pkg::NOVR; g++) begin : g_ovr
      logic [13:0] pv_next, av_next, eff_next;
      logic        pvl_next, avl_next, apply;
      always_comb begin
        pv_next  = pend_val[g];
        pvl_next = pend_vld[g];
        av_next  = act_val[g];
        avl_next = act_vld[g];
        // interpolation times wait for an interpolation move in pass mode
        apply = i_motion_start && pend_vld[g]
                && (!pass_reg || (g % 4 < 2) || i_motion_interp);
        if (apply) begin
          av_next  = pend_val[g];
          avl_next = 1'b1;
          pvl_next = 1'b0;
        end
        if (ovr_we && (oidx_reg == 3'(g))) begin
          pv_next  = ovr_val;
          pvl_next = 1'b1;
        end
        if (i_main_start) begin
          pvl_next = 1'b0;
          avl_next = 1'b0;
        end
        eff_next = act_vld[g] ? act_val[g] : i_sys_time[g];
      end
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          pend_val[g]   <= 14'h0000;
          pend_vld[g]   <= 1'b0;
          act_val[g]    <= 14'h0000;
          act_vld[g]    <= 1'b0;
          o_eff_time[g] <= 14'h0000;
        end else begin
          pend_val[g]   <= pv_next;
          pend_vld[g]   <= pvl_next;
          act_val[g]    <= av_next;
          act_vld[g]    <= avl_next;
          o_eff_time[g] <= eff_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // assertions
  sequence s_accept_pd;
    (state_reg == S_IDLE) && i_cmd_valid && (i_s2_sel == mpd_pkg::SRC_PD);
  endsequence
  sequence s_fetch;
    o_pd_rd_en ##1 !o_pd_rd_en;
  endsequence

  a_fetch_then_done: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_accept_pd |=> s_fetch ##[1:4] o_cmd_done)
    else $error("position data fetch did not complete the command");

  a_pd_write_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pd_wr_en |-> fmag(96'(o_pd_wr_data)) <= mpd_pkg::POS_MAX_W)
    else $error("position data write outside range");

  a_reg_reset_clear: assert property (@(posedge i_clk)
    !i_rst_n |=> (idx_reg[0] == 11'h000) && (idx_reg[NREG-1] == 11'h000))
    else $error("index register not cleared by reset");

  a_div_zero_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == S_EXEC) && div0 && !bad_reg
    |=> o_cmd_err && !o_pd_wr_en && st_reg[mpd_pkg::ST_DIV0])
    else $error("divide by zero not reported");

  a_ovr_pend_range: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ovr_we && !i_main_start |=> pend_vld[oidx_reg] && (pend_val[oidx_reg] <= mpd_pkg::OVR_MAX))
    else $error("override stored outside range");

  a_main_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_main_start |=> (act_vld == 8'h00) && (pend_vld == 8'h00))
    else $error("override survived main program start");

  a_sys_passthru: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !act_vld[0] |=> o_eff_time[0] == $past(i_sys_time[0]))
    else $error("system parameter not used without override");

  a_stop_apply: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pend_vld[0] && i_motion_start && !i_main_start
    |=> act_vld[0] && (act_val[0] == $past(pend_val[0])) ##1 o_eff_time[0] == $past(act_val[0]))
    else $error("acceleration override not applied at motion start");

  a_pass_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pass_reg && pend_vld[6] && i_motion_start && !i_motion_interp && !i_main_start
    |=> pend_vld[6] && $stable(act_val[6]))
    else $error("interpolation override applied outside interpolation");
endmodule
`default_nettype wire

// File: hw/mpd_pkg.sv
// package: constants and types for the motion program data operations block
package mpd_pkg;
  // fixed point: value times ten thousand, four fractional decimal digits
  localparam int VW = 48;
  localparam int PW = 96;
  localparam logic signed [47:0] FRAC      = 48'sh0000_0000_2710;
  localparam logic signed [95:0] FRAC_W    = 96'(FRAC);
  localparam logic signed [95:0] POS_MAX_W = 96'sh00_5D21_DB78F0;
  localparam logic        [10:0] REG_MAX   = 11'h7CF;
  localparam logic        [13:0] OVR_MAX   = 14'h270F;
  localparam logic signed [95:0] REG_LIM_W = 96'(REG_MAX) * FRAC_W;
  localparam logic signed [95:0] OVR_LIM_W = 96'(OVR_MAX) * FRAC_W;

  localparam int NAX   = 2;
  localparam int NTYPE = 4;
  localparam int NOVR  = NAX * NTYPE;
  localparam int TW    = 14;
  localparam int RW    = 11;
  localparam int AW    = 11;

  // register offsets, byte addresses
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_INT_EN  = 8'h04;
  localparam logic [7:0] OFS_INT_CLR = 8'h08;
  localparam logic [7:0] OFS_CTRL    = 8'h0C;
  localparam logic [7:0] OFS_SCALE_X = 8'h10;
  localparam logic [7:0] OFS_SCALE_Y = 8'h14;
  localparam logic [7:0] OFS_OVR_ACT = 8'h18;

  // status, enable and clear share this layout
  localparam int ST_DONE  = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_DIV0  = 2;
  localparam int STW      = 3;
  localparam int CTRL_PASS = 0;

  localparam logic [2:0]  ST_RST    = 3'h0;
  localparam logic [0:0]  CTRL_RST  = 1'h0;
  localparam logic [31:0] SCALE_RST = 32'h0000_2710;

  typedef enum logic [1:0] {CMD_ARITH, CMD_COPY, CMD_OVR} kind_e;
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} op_e;
  typedef enum logic [1:0] {SRC_PD, SRC_REG, SRC_IMM, SRC_AXIS} src_e;
endpackage

// File: verif/mpd_pd_model.sv
// position data store model answering the block's read and write pulses
`timescale 1ns/1ps
`default_nettype none
module mpd_pd_model (
  input  wire logic               i_clk,
  input  wire logic               i_rd_en,
  input  wire logic [10:0]        i_rd_addr,
  output logic signed [47:0]      o_rd_data,
  input  wire logic               i_wr_en,
  input  wire logic [10:0]        i_wr_addr,
  input  wire logic signed [47:0] i_wr_data
);
  logic signed [47:0] mem [2048];
  logic signed [47:0] last_reg;
  logic               vld_reg;
  initial begin
    mem[1] = 48'sh0000_0001_E848;
    mem[2] = -48'sh0000_0000_7530;
    last_reg = 48'sh0;
    vld_reg = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_wr_en) mem[i_wr_addr] <= i_wr_data;
    vld_reg <= i_rd_en;
    if (i_rd_en) last_reg <= mem[i_rd_addr];
  end
  // data valid only in the cycle after the read pulse
  assign o_rd_data = vld_reg ? last_reg : ~last_reg;
endmodule
`default_nettype wire

// File: verif/test_motion_program_data_ops.sv
// testbench for the motion program data operations block
`timescale 1ns/1ps
`default_nettype none
module test_motion_program_data_ops;
  logic i_clk, i_rst_n, i_wr, i_rd, o_irq, i_cmd_valid, i_dst_reg, i_ovr_axis;
  logic o_cmd_ready, o_cmd_done, o_cmd_err, i_motion_start, i_motion_interp, i_main_start;
  logic o_pd_rd_en, o_pd_wr_en, we;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [10:0] i_dst_addr, o_pd_rd_addr, o_pd_wr_addr;
  logic [2:0] i_ovr_type;
  logic signed [47:0] i_s2_imm, i_s3_imm, i_pd_rd_data, o_pd_wr_data, wd;
  logic signed [31:0] i_pos_x, i_pos_y;
  logic [13:0] i_sys_time [mpd_pkg::NOVR];
  logic [13:0] o_eff_time [mpd_pkg::NOVR];
  mpd_pkg::kind_e i_cmd_kind;
  mpd_pkg::op_e i_op;
  mpd_pkg::src_e i_s2_sel, i_s3_sel;
  int err_total, checks_done;
  mpd_core u_mpd_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_cmd_valid(i_cmd_valid),
    .i_cmd_kind(i_cmd_kind), .i_op(i_op), .i_dst_reg(i_dst_reg), .i_dst_addr(i_dst_addr),
    .i_s2_sel(i_s2_sel), .i_s2_addr(i_s2_imm[10:0]), .i_s2_imm(i_s2_imm),
    .i_s3_sel(i_s3_sel), .i_s3_addr(i_s3_imm[10:0]), .i_s3_imm(i_s3_imm),
    .i_ovr_type(i_ovr_type), .i_ovr_axis(i_ovr_axis), .o_cmd_ready(o_cmd_ready),
    .o_cmd_done(o_cmd_done), .o_cmd_err(o_cmd_err), .i_motion_start(i_motion_start),
    .i_motion_interp(i_motion_interp), .i_main_start(i_main_start), .i_pos_x(i_pos_x),
    .i_pos_y(i_pos_y), .o_pd_rd_en(o_pd_rd_en), .o_pd_rd_addr(o_pd_rd_addr),
    .i_pd_rd_data(i_pd_rd_data), .o_pd_wr_en(o_pd_wr_en), .o_pd_wr_addr(o_pd_wr_addr),
    .o_pd_wr_data(o_pd_wr_data), .i_sys_time(i_sys_time), .o_eff_time(o_eff_time));
  mpd_pd_model u_mpd_pd_model (.i_clk(i_clk), .i_rd_en(o_pd_rd_en), .i_rd_addr(o_pd_rd_addr),
    .o_rd_data(i_pd_rd_data), .i_wr_en(o_pd_wr_en), .i_wr_addr(o_pd_wr_addr),
    .i_wr_data(o_pd_wr_data));
  // ==========================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask
  task automatic cmd(input mpd_pkg::kind_e k, input mpd_pkg::op_e op, input logic dr,
      input logic [10:0] da, input mpd_pkg::src_e s2, input logic [47:0] v2,
      input mpd_pkg::src_e s3, input logic [47:0] v3, input logic ee);
    int n;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_kind <= k;
    i_op <= op;
    i_dst_reg <= dr;
    i_dst_addr <= da;
    i_s2_sel <= s2;
    i_s2_imm <= v2;
    i_s3_sel <= s3;
    i_s3_imm <= v3;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      #1;
      if (n == 0) chk(o_cmd_ready, 1'b0);
      if (o_cmd_done === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      report_and_stop();
    end
    wd = o_pd_wr_data;
    we = o_pd_wr_en;
    chk(o_cmd_ready, 1'b1);
    chk(o_cmd_err, ee);
  endtask
  task automatic cp(input logic dr, input logic [10:0] da, input mpd_pkg::src_e s,
      input logic [47:0] v, input logic ee);
    cmd(mpd_pkg::CMD_COPY, mpd_pkg::OP_ADD, dr, da, s, v, mpd_pkg::SRC_IMM, 48'h0, ee);
  endtask
  task automatic ov(input logic [2:0] ty, input logic ax, input mpd_pkg::src_e s,
      input logic [47:0] v, input logic ee);
    @(posedge i_clk);
    i_ovr_type <= ty;
    i_ovr_axis <= ax;
    cmd(mpd_pkg::CMD_OVR, mpd_pkg::OP_ADD, 1'b0, 11'h0, s, v, mpd_pkg::SRC_IMM, 48'h0, ee);
  endtask
  task automatic mot(input logic ip, input logic m);
    @(posedge i_clk);
    i_motion_start <= ~m;
    i_motion_interp <= ip;
    i_main_start <= m;
    @(posedge i_clk);
    i_motion_start <= 1'b0;
    i_motion_interp <= 1'b0;
    i_main_start <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset_and_data();
    logic [47:0] ex [4] = '{48'h17318, 48'hD6D8, 48'h249F0, 48'h927C};
    rd(mpd_pkg::OFS_SCALE_X, mpd_pkg::SCALE_RST);
    rd(8'h1C, 32'h0);
    cp(1'b0, 11'h00A, mpd_pkg::SRC_REG, 48'h5, 1'b0);
    chk(wd, 48'h0);
    chk(we, 1'b1);
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_ADD, 1'b0, 11'h3, mpd_pkg::SRC_PD, 48'h1,
        mpd_pkg::SRC_PD, 48'h2, 1'b0);
    chk(wd, 48'h17318);
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_SUB, 1'b0, 11'h4, mpd_pkg::SRC_IMM, 48'h2710,
        mpd_pkg::SRC_PD, 48'h2, 1'b0);
    chk(wd, 48'h9C40);
    for (int i = 0; i < 4; i++) begin
      cmd(mpd_pkg::CMD_ARITH, mpd_pkg::op_e'(i), 1'b0, 11'h4, mpd_pkg::SRC_IMM, 48'h124F8,
          mpd_pkg::SRC_IMM, 48'h4E20, 1'b0);
      chk(wd, ex[i]);
    end
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_DIV, 1'b0, 11'h4, mpd_pkg::SRC_IMM, 48'h2710,
        mpd_pkg::SRC_IMM, 48'h7530, 1'b0);
    chk(wd, 48'hD05);
  endtask
  task automatic t_registers();
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_ADD, 1'b1, 11'h1, mpd_pkg::SRC_IMM, 48'h61A8,
        mpd_pkg::SRC_IMM, 48'h61A8, 1'b0);
    cp(1'b0, 11'h5, mpd_pkg::SRC_REG, 48'h1, 1'b0);
    chk(wd, 48'hEA60);
    cp(1'b1, 11'h2, mpd_pkg::SRC_IMM, 48'h61A8, 1'b0);
    cp(1'b0, 11'h5, mpd_pkg::SRC_REG, 48'h2, 1'b0);
    chk(wd, 48'h7530);
    cp(1'b0, 11'h8, mpd_pkg::SRC_AXIS, 48'h0, 1'b0);
    chk(wd, 48'h11170);
    wr(mpd_pkg::OFS_SCALE_Y, 32'h4E20);
    cp(1'b0, 11'h8, mpd_pkg::SRC_AXIS, 48'h1, 1'b0);
    chk(wd, 48'hFFFF_FFFF_63C0);
  endtask
  task automatic t_errors();
    cp(1'b0, 11'h6, mpd_pkg::SRC_IMM, 48'h5D_21DB_A000, 1'b1);
    chk(we, 1'b0);
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_ADD, 1'b0, 11'h6, mpd_pkg::SRC_IMM, 48'h5D_21DB_78F0,
        mpd_pkg::SRC_IMM, 48'h2710, 1'b1);
    cp(1'b1, 11'h3, mpd_pkg::SRC_IMM, 48'h131_05F0, 1'b0);
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_ADD, 1'b1, 11'h3, mpd_pkg::SRC_REG, 48'h3,
        mpd_pkg::SRC_IMM, 48'h2710, 1'b1);
    cp(1'b0, 11'h5, mpd_pkg::SRC_REG, 48'h3, 1'b0);
    chk(wd, 48'h131_05F0);
    cmd(mpd_pkg::CMD_ARITH, mpd_pkg::OP_DIV, 1'b0, 11'h7, mpd_pkg::SRC_IMM, 48'h2710,
        mpd_pkg::SRC_IMM, 48'h0, 1'b1);
    chk(we, 1'b0);
  endtask
  task automatic t_override();
    ov(3'h1, 1'b0, mpd_pkg::SRC_IMM, 48'h7A120, 1'b0);
    chk(o_eff_time[0], 14'h64);
    mot(1'b0, 1'b0);
    chk(o_eff_time[0], 14'h32);
    ov(3'h2, 1'b1, mpd_pkg::SRC_PD, 48'h1, 1'b0);
    ov(3'h4, 1'b1, mpd_pkg::SRC_IMM, 48'h5F5_E100, 1'b1);
    ov(3'h5, 1'b1, mpd_pkg::SRC_IMM, 48'h2710, 1'b1);
    wr(mpd_pkg::OFS_CTRL, 32'h1);
    ov(3'h3, 1'b1, mpd_pkg::SRC_IMM, 48'h30D40, 1'b0);
    mot(1'b0, 1'b0);
    chk(o_eff_time[5], 14'hD);
    chk(o_eff_time[6], 14'h6A);
    mot(1'b1, 1'b0);
    chk(o_eff_time[6], 14'h14);
    rd(mpd_pkg::OFS_OVR_ACT, 32'h61);
    mot(1'b0, 1'b1);
    rd(mpd_pkg::OFS_OVR_ACT, 32'h0);
    chk(o_eff_time[0], 14'h64);
    chk(o_eff_time[6], 14'h6A);
  endtask
  task automatic t_irq();
    wr(mpd_pkg::OFS_INT_CLR, 32'h7);
    wr(mpd_pkg::OFS_INT_EN, 32'h1);
    chk(o_irq, 1'b0);
    cp(1'b1, 11'h4, mpd_pkg::SRC_IMM, 48'h0, 1'b0);
    #50;
    chk(o_irq, 1'b1);
    rd(mpd_pkg::OFS_STATUS, 32'h1);
    rd(mpd_pkg::OFS_INT_CLR, 32'h0);
    wr(mpd_pkg::OFS_INT_EN, 32'h0);
    chk(o_irq, 1'b0);
  endtask
  task automatic t_reset_mid();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cp(1'b0, 11'h5, mpd_pkg::SRC_REG, 48'h3, 1'b0);
    chk(we, 1'b1);
    chk(wd, 48'h0);
  endtask
  // ==========================================
  // clock, reset and sequence
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_cmd_valid, i_dst_reg, i_ovr_axis} = '0;
    {i_motion_start, i_motion_interp, i_main_start} = '0;
    {i_addr, i_wdata, i_dst_addr, i_ovr_type, i_s2_imm, i_s3_imm} = '0;
    i_cmd_kind = mpd_pkg::CMD_ARITH;
    i_op = mpd_pkg::OP_ADD;
    i_s2_sel = mpd_pkg::SRC_IMM;
    i_s3_sel = mpd_pkg::SRC_IMM;
    i_pos_x = 32'sh7;
    i_pos_y = -32'sh2;
    for (int i = 0; i < mpd_pkg::NOVR; i++) i_sys_time[i] = 14'(8'h64 + i);
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset_and_data();
    t_registers();
    t_errors();
    t_override();
    t_irq();
    t_reset_mid();
    report_and_stop();
  end
endmodule
`default_nettype wire
